// ### design/tisel_top.sv
// How it works
// (RULE_01) rx bit 6 picks channel 2 input: pin 2 or uart 2 receive
// (RULE_02) rx bits 3:2 feed channel 1: pin 1, can 1 stamp, uart 11
// (RULE_03) rx bits 1:0 feed channel 0: pin 0, can 0 stamp, alternate
// (RULE_04) stamp bit 5 feeds channel 15: pin 15 or alt controller stamp
// (RULE_05) stamp bit 3 feeds channel 13: pin 13 or can 3 stamp
// (RULE_06) stamp bit 2 drives channel 12: pin 12 or can 2 stamp
// (RULE_07) stamp bit 1 feeds channel 11: pin 11 or can 1 stamp
// (RULE_08) stamp bit 0 drives channel 10: pin 10 or can 0 stamp
// (RULE_09) irq bit 1 feeds channel 15 with secondary timer irq
// (RULE_10) irq bit 0 picks uart 10 or irq as channel 0 alternate
// (RULE_11) software keeps stamp bit 4 at zero
// (RULE_12) four select registers are byte wide and reset to zero
// (RULE_13) odd channels may take the even neighbour per chain register
// (RULE_14) selectors follow a register write from the next edge
// (RULE_15) unused bits read zero, stamp bit 4 is stored
`timescale 1ns/100ps
`default_nettype none
module tisel_top (
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [tisel_pkg::TISEL_ADR_W-1:0] wb_adr_i,
  input  wire logic [tisel_pkg::TISEL_DAT_W-1:0] wb_dat_i,
  input  wire logic [tisel_pkg::TISEL_SEL_W-1:0] wb_sel_i,
  output logic      [tisel_pkg::TISEL_DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [tisel_pkg::TISEL_CH_N-1:0]  timer_input_pin_i,
  input  wire logic                          uart2_receive_line_i,
  input  wire logic                          uart10_receive_line_i,
  input  wire logic                          uart11_receive_line_i,
  input  wire logic                          can_controller_0_stamp_i,
  input  wire logic                          can_controller_1_stamp_i,
  input  wire logic                          can_controller_2_stamp_i,
  input  wire logic                          can_controller_3_stamp_i,
  input  wire logic                          alt_controller_0_stamp_i,
  input  wire logic                          secondary_timer_ch3_irq_i,
  output logic      [tisel_pkg::TISEL_CH_N-1:0]  timer_channel_input_o
);

  import tisel_pkg::*;

  function automatic logic addr_hit(
    input logic [TISEL_ADR_W-1:0] adr,
    input logic [TISEL_ADR_W-1:0] reg_adr
  );
    return adr == reg_adr;
  endfunction

  // x0 gives the pin; both 2-bit selectors share this decode
  function automatic logic pick4(
    input logic [TISEL_CODE_W-1:0] code,
    input logic                    pin,
    input logic                    can,
    input logic                    alt
  );
    logic res;
    res = pin;
    if (code == TISEL_PICK_CAN) begin
      res = can;
    end else if (code == TISEL_PICK_ALT) begin
      res = alt;
    end
    return res;
  endfunction

  // ---- synchronised inputs
  logic [TISEL_SYNC_W-1:0] sync_d;
  logic [TISEL_SYNC_W-1:0] sync_s;

  assign sync_d = {secondary_timer_ch3_irq_i,
                   alt_controller_0_stamp_i,
                   can_controller_3_stamp_i,
                   can_controller_2_stamp_i,
                   can_controller_1_stamp_i,
                   can_controller_0_stamp_i,
                   uart11_receive_line_i,
                   uart10_receive_line_i,
                   uart2_receive_line_i,
                   timer_input_pin_i};

  tisel_sync #(
    .WIDTH (TISEL_SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (sync_d),
    .q_o     (sync_s)
  );

  wire [TISEL_CH_N-1:0] pin_s    = sync_s[TISEL_CH_N-1:0];
  wire                  uart2_s  = sync_s[TISEL_SY_UART2];
  wire                  uart10_s = sync_s[TISEL_SY_UART10];
  wire                  uart11_s = sync_s[TISEL_SY_UART11];
  wire                  can0_s   = sync_s[TISEL_SY_CAN0];
  wire                  can1_s   = sync_s[TISEL_SY_CAN1];
  wire                  can2_s   = sync_s[TISEL_SY_CAN2];
  wire                  can3_s   = sync_s[TISEL_SY_CAN3];
  wire                  alt0_s   = sync_s[TISEL_SY_ALT0];
  wire                  irq_s    = sync_s[TISEL_SY_IRQ];

  // ---- wishbone slave
  tisel_bus_st_t            st_q;
  tisel_bus_st_t            st_d;
  logic                     ack_q;
  logic [TISEL_DAT_W-1:0]   dat_q;
  logic [TISEL_DAT_W-1:0]   dat_d;
  logic [TISEL_REG_W-1:0]   rx_q;
  logic [TISEL_REG_W-1:0]   rx_d;
  logic [TISEL_REG_W-1:0]   ts_q;
  logic [TISEL_REG_W-1:0]   ts_d;
  logic [TISEL_REG_W-1:0]   irq_q;
  logic [TISEL_REG_W-1:0]   irq_d;
  logic [TISEL_REG_W-1:0]   chain_q;
  logic [TISEL_REG_W-1:0]   chain_d;

  wire req      = wb_cyc_i & wb_stb_i;
  wire hit_rx   = addr_hit(wb_adr_i, TISEL_RX_SRC_ADR);
  wire hit_ts   = addr_hit(wb_adr_i, TISEL_TS_SRC_ADR);
  wire hit_irq  = addr_hit(wb_adr_i, TISEL_IRQ_SRC_ADR);
  wire hit_chn  = addr_hit(wb_adr_i, TISEL_CHAIN_ADR);

  // a write lands on the edge where ack is seen, lane 0 only
  wire wr_en    = req & wb_we_i & ack_q & wb_sel_i[TISEL_LANE0];

  wire [TISEL_REG_W-1:0] wr_byte = wb_dat_i[TISEL_REG_W-1:0];

  // unused bits are masked off on the way in  (see RULE_15)
  assign rx_d    = (wr_en & hit_rx)  ? (wr_byte & TISEL_RX_MASK)  : rx_q;
  assign ts_d    = (wr_en & hit_ts)  ? (wr_byte & TISEL_TS_MASK)  : ts_q;
  assign irq_d   = (wr_en & hit_irq) ? (wr_byte & TISEL_IRQ_MASK) : irq_q;
  assign chain_d = (wr_en & hit_chn) ? (wr_byte & TISEL_CHN_MASK) : chain_q;

  // unmapped addresses still ack, reading zero
  wire [TISEL_REG_W-1:0] rd_byte = hit_rx  ? rx_q :
                                   hit_ts  ? ts_q :
                                   hit_irq ? irq_q :
                                   hit_chn ? chain_q :
                                   TISEL_REG_RST;

  wire [TISEL_DAT_W-1:0] rd_word =
    {{(TISEL_DAT_W-TISEL_REG_W){1'b0}}, rd_byte};

  always_comb begin
    case (st_q)
      TISEL_BUS_IDLE: begin
        st_d = req ? TISEL_BUS_ACK : TISEL_BUS_IDLE;
      end
      TISEL_BUS_ACK: begin
        st_d = TISEL_BUS_IDLE;
      end
      default: begin
        st_d = TISEL_BUS_IDLE;
      end
    endcase
  end

  assign dat_d = (st_q == TISEL_BUS_IDLE && req) ? rd_word : '0;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q  <= TISEL_BUS_IDLE;
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      st_q  <= st_d;
      ack_q <= (st_d == TISEL_BUS_ACK);
      dat_q <= dat_d;
    end
  end

  // cleared to pin routing on reset  (see RULE_12)
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rx_q    <= TISEL_REG_RST;
      ts_q    <= TISEL_REG_RST;
      irq_q   <= TISEL_REG_RST;
      chain_q <= TISEL_REG_RST;
    end else begin
      rx_q    <= rx_d;
      ts_q    <= ts_d;
      irq_q   <= irq_d;
      chain_q <= chain_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ---- source selectors, combinational up to the registered chain stage  (see RULE_14)
  logic [TISEL_CH_N-1:0] pre_w;

  wire ch0_alt = irq_q[TISEL_IRQ_CH0_BIT] ? irq_s : uart10_s; // see RULE_10

  assign pre_w[0] = pick4(rx_q[TISEL_RX_CH0_LSB +: TISEL_CODE_W],
                          pin_s[0], can0_s, ch0_alt); // see RULE_03
  assign pre_w[1] = pick4(rx_q[TISEL_RX_CH1_LSB +: TISEL_CODE_W],
                          pin_s[1], can1_s, uart11_s); // see RULE_02
  assign pre_w[2] = rx_q[TISEL_RX_CH2_BIT] ? uart2_s : pin_s[2]; // see RULE_01

  assign pre_w[10] = ts_q[TISEL_TS_CH10_BIT] ? can0_s : pin_s[10]; // see RULE_08
  assign pre_w[11] = ts_q[TISEL_TS_CH11_BIT] ? can1_s : pin_s[11]; // see RULE_07
  assign pre_w[12] = ts_q[TISEL_TS_CH12_BIT] ? can2_s : pin_s[12]; // see RULE_06
  assign pre_w[13] = ts_q[TISEL_TS_CH13_BIT] ? can3_s : pin_s[13]; // see RULE_05

  // irq pick overrides the stamp pick on channel 15
  wire ch15_stamp = ts_q[TISEL_TS_CH15_BIT] ? alt0_s : pin_s[15]; // see RULE_04
  assign pre_w[15] = irq_q[TISEL_IRQ_CH15_BIT] ? irq_s : ch15_stamp; // see RULE_09

  genvar k;
  generate
    for (k = 0; k < TISEL_CH_N; k++) begin : g_direct
      if (TISEL_DIRECT_MASK[k]) begin : g_pin
        assign pre_w[k] = pin_s[k];
      end
    end
  endgenerate

  tisel_chain #(
    .CH_N (TISEL_CH_N)
  ) u_chain (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pre_i   (pre_w),
    .chain_i (chain_q),
    .chan_o  (timer_channel_input_o)
  );

  // ---- checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  wire [TISEL_CH_N-1:0] out = timer_channel_input_o;

  AST_CH2_SRC: assert property ( // see RULE_01
    out[2] == $past(rx_q[TISEL_RX_CH2_BIT] ? uart2_s : pin_s[2]) or $past(!rst_b_i))
    else $error("channel 2 source wrong");

  AST_CH1_UART: assert property ( // see RULE_02
    !chain_q[0] && rx_q[TISEL_RX_CH1_LSB +: TISEL_CODE_W] == TISEL_PICK_ALT
    |=> out[1] == $past(uart11_s))
    else $error("channel 1 not on uart 11");

  AST_CH0_CAN: assert property ( // see RULE_03
    rx_q[TISEL_RX_CH0_LSB +: TISEL_CODE_W] == TISEL_PICK_CAN
    |=> out[0] == $past(can0_s))
    else $error("channel 0 not on can 0 stamp");

  AST_CH15_STAMP: assert property ( // see RULE_04
    !chain_q[7] && !irq_q[TISEL_IRQ_CH15_BIT] && ts_q[TISEL_TS_CH15_BIT]
    |=> out[15] == $past(alt0_s))
    else $error("channel 15 not on alt stamp");

  AST_CH13_CAN: assert property ( // see RULE_05
    !chain_q[6] && ts_q[TISEL_TS_CH13_BIT] |=> out[13] == $past(can3_s))
    else $error("channel 13 not on can 3 stamp");

  AST_CH12_SRC: assert property ( // see RULE_06
    1'b1
    |=> out[12] == $past(ts_q[TISEL_TS_CH12_BIT] ? can2_s : pin_s[12]))
    else $error("channel 12 source wrong");

  AST_CH11_CAN: assert property ( // see RULE_07
    !chain_q[5] && ts_q[TISEL_TS_CH11_BIT] |=> out[11] == $past(can1_s))
    else $error("channel 11 not on can 1 stamp");

  AST_CH10_PIN: assert property ( // see RULE_08
    !ts_q[TISEL_TS_CH10_BIT] |=> out[10] == $past(pin_s[10]))
    else $error("channel 10 not on its pin");

  AST_CH15_IRQ: assert property ( // see RULE_09
    !chain_q[7] && irq_q[TISEL_IRQ_CH15_BIT] |=> out[15] == $past(irq_s))
    else $error("channel 15 not on secondary irq");

  AST_CH0_IRQ: assert property ( // see RULE_10
    rx_q[TISEL_RX_CH0_LSB +: TISEL_CODE_W] == TISEL_PICK_ALT
    && irq_q[TISEL_IRQ_CH0_BIT] |=> out[0] == $past(irq_s))
    else $error("channel 0 not on secondary irq");

  AST_RX_WRITE: assert property ( // see RULE_12
    wr_en && hit_rx |=> rx_q == ($past(wr_byte) & TISEL_RX_MASK))
    else $error("receive select write lost");

  AST_CHAIN_ODD: assert property ( // see RULE_13
    chain_q[1] |=> out[3] == out[2])
    else $error("channel 3 not chained to 2");

  AST_WRITE_LAT: assert property ( // see RULE_14
    wr_en && hit_rx && wr_byte[TISEL_RX_CH2_BIT]
    |=> ##1 out[2] == $past(uart2_s))
    else $error("channel 2 did not follow write");

  AST_RSV_ZERO: assert property ( // see RULE_15
    (ts_q & ~TISEL_TS_MASK) == '0 && (rx_q & ~TISEL_RX_MASK) == '0
    && (irq_q & ~TISEL_IRQ_MASK) == '0)
    else $error("reserved select bit set");

  AST_TS_KEEP: assert property ( // see RULE_15
    wr_en && hit_ts |=> ts_q[TISEL_TS_KEEP_BIT] == $past(wr_byte[TISEL_TS_KEEP_BIT]))
    else $error("stamp bit 4 not stored");

  AST_ACK_ONE: assert property (
    ack_q |=> !ack_q)
    else $error("ack longer than one cycle");

  AST_ACK_LAT: assert property ( // see RULE_12
    st_q == TISEL_BUS_IDLE && req |=> ack_q)
    else $error("ack not one cycle after request");

  AST_DAT_IDLE: assert property ( // see RULE_12
    !ack_q |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");

  AST_RD_DATA: assert property ( // see RULE_12
    st_q == TISEL_BUS_IDLE && req && !wb_we_i && hit_ts
    |=> wb_dat_o[TISEL_REG_W-1:0] == $past(ts_q))
    else $error("stamp select read data wrong");

  AST_RST_REGS: assert property ( // see RULE_12
    $past(!rst_b_i) |-> rx_q == TISEL_REG_RST && ts_q == TISEL_REG_RST
    && irq_q == TISEL_REG_RST && chain_q == TISEL_REG_RST)
    else $error("select register not cleared by reset");

  AST_CH1_CAN: assert property ( // see RULE_02
    !chain_q[0] && rx_q[TISEL_RX_CH1_LSB +: TISEL_CODE_W] == TISEL_PICK_CAN
    |=> out[1] == $past(can1_s))
    else $error("channel 1 not on can 1 stamp");

  AST_CH0_UART: assert property ( // see RULE_10
    rx_q[TISEL_RX_CH0_LSB +: TISEL_CODE_W] == TISEL_PICK_ALT
    && !irq_q[TISEL_IRQ_CH0_BIT] |=> out[0] == $past(uart10_s))
    else $error("channel 0 not on uart 10");

  COV_WRITE: cover property (
    wr_en && hit_ts);

  COV_CHAIN: cover property (
    chain_q[7] && irq_q[TISEL_IRQ_CH15_BIT]);

  COV_UART2: cover property (
    rx_q[TISEL_RX_CH2_BIT] && $rose(uart2_s));

  COV_CH0_IRQ: cover property (
    rx_q[TISEL_RX_CH0_LSB +: TISEL_CODE_W] == TISEL_PICK_ALT && irq_q[TISEL_IRQ_CH0_BIT]);

  COV_READ: cover property (
    ack_q && !wb_we_i);

endmodule
`default_nettype wire

// ### design/tisel_pkg.sv
package tisel_pkg;

  localparam int TISEL_ADR_W  = 32;
  localparam int TISEL_DAT_W  = 32;
  localparam int TISEL_SEL_W  = 4;
  localparam int TISEL_REG_W  = 8;
  localparam int TISEL_CODE_W = 2;
  localparam int TISEL_CH_N   = 16;
  localparam int TISEL_LANE0  = 0;

  // register byte addresses
  localparam logic [TISEL_ADR_W-1:0] TISEL_IRQ_SRC_ADR = 32'hff770418;
  localparam logic [TISEL_ADR_W-1:0] TISEL_CHAIN_ADR   = 32'hff771000;
  localparam logic [TISEL_ADR_W-1:0] TISEL_RX_SRC_ADR  = 32'hff771004;
  localparam logic [TISEL_ADR_W-1:0] TISEL_TS_SRC_ADR  = 32'hff772014;

  localparam logic [TISEL_REG_W-1:0] TISEL_REG_RST  = 8'h00;
  localparam logic [TISEL_REG_W-1:0] TISEL_RX_MASK  = 8'h4f;
  localparam logic [TISEL_REG_W-1:0] TISEL_TS_MASK  = 8'h3f;
  localparam logic [TISEL_REG_W-1:0] TISEL_IRQ_MASK = 8'h03;
  localparam logic [TISEL_REG_W-1:0] TISEL_CHN_MASK = 8'hff;

  // field positions
  localparam int TISEL_RX_CH2_BIT  = 6;
  localparam int TISEL_RX_CH1_LSB  = 2;
  localparam int TISEL_RX_CH0_LSB  = 0;
  localparam int TISEL_TS_CH15_BIT = 5;
  localparam int TISEL_TS_KEEP_BIT = 4;
  localparam int TISEL_TS_CH13_BIT = 3;
  localparam int TISEL_TS_CH12_BIT = 2;
  localparam int TISEL_TS_CH11_BIT = 1;
  localparam int TISEL_TS_CH10_BIT = 0;
  localparam int TISEL_IRQ_CH15_BIT = 1;
  localparam int TISEL_IRQ_CH0_BIT  = 0;

  // two-bit pick codes; x0 selects the port pin
  localparam logic [TISEL_CODE_W-1:0] TISEL_PICK_CAN = 2'h1;
  localparam logic [TISEL_CODE_W-1:0] TISEL_PICK_ALT = 2'h3;

  // synchroniser vector layout
  localparam int TISEL_SY_UART2  = 16;
  localparam int TISEL_SY_UART10 = 17;
  localparam int TISEL_SY_UART11 = 18;
  localparam int TISEL_SY_CAN0   = 19;
  localparam int TISEL_SY_CAN1   = 20;
  localparam int TISEL_SY_CAN2   = 21;
  localparam int TISEL_SY_CAN3   = 22;
  localparam int TISEL_SY_ALT0   = 23;
  localparam int TISEL_SY_IRQ    = 24;
  localparam int TISEL_SYNC_W    = 25;

  // channels whose input is the bare port pin
  localparam logic [TISEL_CH_N-1:0] TISEL_DIRECT_MASK = 16'h43f8;

  typedef enum logic {
    TISEL_BUS_IDLE = 1'b0,
    TISEL_BUS_ACK  = 1'b1
  } tisel_bus_st_t;

endpackage

// ### design/tisel_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tisel_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ### design/tisel_chain.sv
`timescale 1ns/100ps
`default_nettype none
module tisel_chain #(
  parameter int CH_N = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [CH_N-1:0]   pre_i,
  input  wire logic [CH_N/2-1:0] chain_i,
  output logic      [CH_N-1:0]   chan_o
);

  logic [CH_N-1:0] chan_d;

  genvar p;
  generate
    for (p = 0; p < CH_N/2; p++) begin : g_pair
      assign chan_d[2*p]   = pre_i[2*p];
      // odd input borrows its even neighbour  (see RULE_13)
      assign chan_d[2*p+1] = chain_i[p] ? pre_i[2*p] : pre_i[2*p+1];
    end
  endgenerate

  // registered so the timer sees a glitch-free input
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      chan_o <= '0;
    end else begin
      chan_o <= chan_d;
    end
  end

endmodule
`default_nettype wire

// ### test/tisel_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// far side sources: port pins, uart receive lines, stamps, secondary irq
// levels move only on a rising edge, so the design's synchronisers see clean steps
module tisel_src_model (
  input  wire logic        clk_i,
  input  wire logic [24:0] src_i,
  output logic      [15:0] pin_o,
  output logic      [8:0]  side_o
);
  always_ff @(posedge clk_i) begin
    pin_o  <= src_i[15:0];
    side_o <= src_i[24:16];
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tisel_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [31:0] adr = '0;
  logic [31:0] dat = '0;
  logic [3:0]  sel = '0;
  logic [31:0] rdat;
  logic        ack;
  logic [24:0] src = '0;
  logic [15:0] pin;
  logic [8:0]  side;
  logic [15:0] chan;
  logic [31:0] rnd = 32'hea11;
  logic [31:0] ra [5];
  logic [7:0]  mk [5];
  logic [7:0]  sh [5];
  logic [31:0] q;
  logic [7:0]  d;
  logic [15:0] ex;
  int          fails = 0;
  int          n_tests = 0;
  int          idx;

  always #10 clk_i = ~clk_i;

  tisel_src_model src_m (.clk_i(clk_i), .src_i(src), .pin_o(pin), .side_o(side));

  tisel_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_input_pin_i(pin), .uart2_receive_line_i(side[0]),
    .uart10_receive_line_i(side[1]), .uart11_receive_line_i(side[2]),
    .can_controller_0_stamp_i(side[3]), .can_controller_1_stamp_i(side[4]),
    .can_controller_2_stamp_i(side[5]), .can_controller_3_stamp_i(side[6]),
    .alt_controller_0_stamp_i(side[7]), .secondary_timer_ch3_irq_i(side[8]),
    .timer_channel_input_o(chan));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // reference mux: iq, cn, rx, ts registers then source vector
  function automatic logic [15:0] ref_mux(input logic [7:0] iq, cn, rx, ts,
                                           input logic [24:0] s);
    logic [15:0] p;
    logic [15:0] o;
    p = s[15:0];
    if (rx[1:0] == 2'h1) p[0] = s[19];
    if (rx[1:0] == 2'h3) p[0] = iq[0] ? s[24] : s[17];
    if (rx[3:2] == 2'h1) p[1] = s[20];
    if (rx[3:2] == 2'h3) p[1] = s[18];
    if (rx[6]) p[2] = s[16];
    if (ts[0]) p[10] = s[19];
    if (ts[1]) p[11] = s[20];
    if (ts[2]) p[12] = s[21];
    if (ts[3]) p[13] = s[22];
    p[15] = iq[1] ? s[24] : (ts[5] ? s[23] : s[15]);
    o = p;
    for (int i = 0; i < 8; i++) begin
      if (cn[i]) o[2*i+1] = p[2*i];
    end
    return o;
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; no latency assumed, bounded wait for ack
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     input logic [3:0] s, output logic [31:0] rd);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= wd;
    sel <= s;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      end_sim();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  initial begin
    ra = '{TISEL_IRQ_SRC_ADR, TISEL_CHAIN_ADR, TISEL_RX_SRC_ADR, TISEL_TS_SRC_ADR,
           32'hff771008};
    mk = '{TISEL_IRQ_MASK, TISEL_CHN_MASK, TISEL_RX_MASK, TISEL_TS_MASK, 8'h00};
    sh = '{default: 8'h00};
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      bus(1'b0, ra[r], '0, 4'hf, q);
      chk("reset value", 32'h0, q);
    end
    for (int it = 0; it < 400; it++) begin
      rnd = xs(rnd);
      src <= rnd[24:0];
      repeat (4) @(posedge clk_i);
      rnd = xs(rnd);
      idx = int'(rnd[2:0]) % 5;
      d = rnd[15:8];
      // software keeps the reserved stamp bit at zero
      if (idx == 3) d[TISEL_TS_KEEP_BIT] = 1'b0;
      bus(1'b1, ra[idx], {rnd[31:24], 16'h0, d}, {rnd[19:17], rnd[20] | rnd[21]}, q);
      if (rnd[20] | rnd[21]) sh[idx] = d & mk[idx];
      ex = ref_mux(sh[0], sh[1], sh[2], sh[3], src);
      @(posedge clk_i);
      #1;
      chk("channel inputs", {16'h0, ex}, {16'h0, chan});
      // selectors must hold while registers and sources stand still
      @(posedge clk_i);
      #1;
      chk("channel hold", {16'h0, ex}, {16'h0, chan});
      bus(1'b0, ra[idx], '0, 4'hf, q);
      chk("read back", {24'h0, sh[idx]}, q);
    end
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
